// ===== xsm_pkg.sv
// package: constants for the extended state enable mask controller
package xsm_pkg;

  // ----------------------------------------------------------------
  // enable mask layout
  // ----------------------------------------------------------------
  localparam int unsigned MASK_W          = 64;
  localparam int unsigned HALF_W          = 32;
  localparam int unsigned BIT_EXPAND      = 63;
  localparam int unsigned BIT_PROFILING   = 62;
  localparam int unsigned BIT_WIDE_VECTOR = 2;
  localparam int unsigned BIT_VECTOR_128  = 1;
  localparam int unsigned BIT_LEGACY_FP   = 0;
  localparam logic [63:0] MASK_RESET      = 64'h0000_0000_0000_0001;
  localparam logic [63:0] MASK_HIGH_RSVD  = 64'hFFFF_FFFF_FFFF_FFF8;
  localparam logic [1:0]  PAIR_ILLEGAL    = 2'h2;
  localparam logic [2:0]  SUPPORTED_BASE  = 3'h7;

  // ----------------------------------------------------------------
  // control register space and control bits
  // ----------------------------------------------------------------
  localparam logic [31:0] IDX_ENABLE_MASK = 32'h0000_0000;
  localparam int unsigned CR4_OS_SAVE_BIT = 18;
  localparam logic [1:0]  RING_0          = 2'h0;

  // ----------------------------------------------------------------
  // save area layout
  // ----------------------------------------------------------------
  localparam logic [15:0] AREA_LEGACY_OFF  = 16'h0000;
  localparam logic [15:0] AREA_LEGACY_SIZE = 16'h0200;
  localparam logic [15:0] AREA_HEADER_OFF  = 16'h0200;
  localparam logic [15:0] AREA_HEADER_SIZE = 16'h0040;
  localparam logic [15:0] AREA_WIDE_SIZE   = 16'h0100;
  localparam logic [5:0]  COMP_LEGACY      = 6'h00;
  localparam logic [5:0]  COMP_VECTOR_128  = 6'h01;
  localparam logic [5:0]  COMP_WIDE_VECTOR = 6'h02;
  localparam logic [5:0]  COMP_HEADER      = 6'h3F;
  localparam logic [5:0]  COMP_PROFILING   = 6'h3E;

endpackage

// ===== xsm_area_map.sv
// module: fixed save area offset and size lookup per state component
`timescale 1ns/1ps
`default_nettype none
module xsm_area_map
  import xsm_pkg::*;
#(
  parameter logic [15:0] WIDE_OFF  = 16'h0240,
  parameter logic [15:0] PROF_OFF  = 16'h0340,
  parameter logic [15:0] PROF_SIZE = 16'h0080
) (
  // query
  input  wire logic [5:0]  comp,
  // answer
  output logic      [15:0] area_off,
  output logic      [15:0] area_size,
  output logic             area_hit
);

  // -------------------------------------------------------------------
  // lookup
  // -------------------------------------------------------------------
  // offsets never move with the enables: disabled parts leave holes
  always_comb begin
    area_off  = 16'h0000;
    area_size = 16'h0000;
    area_hit  = 1'b1;
    unique case (comp)
      COMP_LEGACY, COMP_VECTOR_128: begin // legacy image shares the first block
        area_off  = AREA_LEGACY_OFF;
        area_size = AREA_LEGACY_SIZE;
      end
      COMP_HEADER: begin // header right after legacy image
        area_off  = AREA_HEADER_OFF;
        area_size = AREA_HEADER_SIZE;
      end
      COMP_WIDE_VECTOR: begin // fixed offset, no compaction
        area_off  = WIDE_OFF;
        area_size = AREA_WIDE_SIZE;
      end
      COMP_PROFILING: begin // fixed offset, no compaction
        area_off  = PROF_OFF;
        area_size = PROF_SIZE;
      end
      default: begin
        area_hit = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// ===== xsm_ctrl.sv
// module: extended state enable mask register, write checks and component gating
`timescale 1ns/1ps
`default_nettype none

module xsm_ctrl
  import xsm_pkg::*;
#(
  parameter logic PROFILING_SUPPORTED = 1'b0
) (
  // clock, reset, enable
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              clk_en,
  // processor context
  input  wire logic [31:0]       cr4,
  input  wire logic [1:0]        cpl,
  input  wire logic              real_mode,
  input  wire logic              v86_mode,
  input  wire logic              smm_entry,
  // control register read and write instructions
  input  wire logic              ext_ctrl_reg_read_instr,
  input  wire logic              ext_ctrl_reg_write_instr,
  input  wire logic [31:0]       ctrl_index,
  input  wire logic [31:0]       wr_data_hi,
  input  wire logic [31:0]       wr_data_lo,
  output logic      [31:0]       rd_data_hi,
  output logic      [31:0]       rd_data_lo,
  output logic                   rd_valid,
  output logic                   wr_done,
  // save and restore instructions
  input  wire logic              extended_save_instr,
  input  wire logic              optimized_save_instr,
  input  wire logic              extended_restore_instr,
  input  wire logic [31:0]       op_mask_hi,
  input  wire logic [31:0]       op_mask_lo,
  output logic      [63:0]       save_component_mask,
  output logic                   save_valid,
  output logic      [63:0]       restore_component_mask,
  output logic                   restore_valid,
  // wide vector instruction issue
  input  wire logic              vector_instr,
  output logic                   vector_grant,
  // save area query
  input  wire logic              area_req,
  input  wire logic [5:0]        area_comp,
  output logic      [15:0]       area_off,
  output logic      [15:0]       area_size,
  output logic                   area_valid,
  // faults
  output logic                   general_protection_fault,
  output logic                   invalid_opcode_fault,
  // live state
  output logic      [63:0]       state_component_enable_mask,
  output logic      [63:0]       supported_component_mask,
  output logic                   profiling_extension_enable,
  output logic                   wide_vector_state_enable,
  output logic                   vector_128_state_enable,
  output logic                   legacy_float_state_enable
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  // one flop vector holds everything; pulse fields are cleared each cycle that clk_en is high
  typedef struct packed {
    logic [63:0] mask;
    logic [63:0] supported;
    logic [31:0] rd_hi;
    logic [31:0] rd_lo;
    logic        rd_valid;
    logic        wr_done;
    logic [63:0] sv_mask;
    logic        sv_valid;
    logic [63:0] rs_mask;
    logic        rs_valid;
    logic        vec_grant;
    logic [15:0] a_off;
    logic [15:0] a_size;
    logic        a_valid;
    logic        gp;
    logic        ud;
  } xsm_state_t;

  // registered state and its next value
  xsm_state_t st_ff;
  xsm_state_t nxt_st;

  // combinational answer of the save area map
  logic [15:0] map_off;
  logic [15:0] map_size;
  logic        map_hit;

  // -------------------------------------------------------------------
  // functions
  // -------------------------------------------------------------------
  // capability: legacy, 128-bit and wide vector, plus profiling if built
  function automatic logic [63:0] xsm_supported();
    logic [63:0] s;
    s = {61'h0, SUPPORTED_BASE};
    s[BIT_PROFILING] = PROFILING_SUPPORTED;
    return s;
  endfunction

  // a new mask value is legal only in the documented patterns
  function automatic logic xsm_legal(input logic [63:0] v);
    logic [63:0] rsvd;
    logic        ok;
    rsvd = MASK_HIGH_RSVD & ~xsm_supported(); // bits 63:3 except a built profiling bit
    ok   = 1'b1;
    if ((v & rsvd) != 64'h0) begin
      ok = 1'b0; // bit 63 among these
    end
    if (!v[BIT_LEGACY_FP]) begin
      ok = 1'b0; // legacy float must be one
    end
    if (v[BIT_WIDE_VECTOR:BIT_VECTOR_128] == PAIR_ILLEGAL) begin
      ok = 1'b0; // wide without 128-bit
    end
    return ok;
  endfunction

  // prefix encoded instructions are unusable in these modes
  function automatic logic xsm_prefix_blocked(input logic rm, input logic vm, input logic sm);
    return rm | vm | sm;
  endfunction

  // component selection shared by save and restore: operand and enable mask both set
  function automatic logic [63:0] xsm_gate(input logic [63:0] op, input logic [63:0] en);
    return op & en;
  endfunction

  // -------------------------------------------------------------------
  // save area map
  // -------------------------------------------------------------------
  // pure lookup; its answer is registered only when a query is taken
  xsm_area_map u_map (
    .comp      (area_comp),
    .area_off  (map_off),
    .area_size (map_size),
    .area_hit  (map_hit)
  );

  // -------------------------------------------------------------------
  // request decode
  // -------------------------------------------------------------------
  logic        os_save_en;
  logic        rd_req;
  logic        wr_req;
  logic        ring_ok;
  logic        index_ok;
  logic        vec_ok;
  logic [63:0] wr_val;
  logic [63:0] op_val;

  // operand halves are joined here so every path sees one 64-bit word
  assign os_save_en = cr4[CR4_OS_SAVE_BIT]; // gates the control register instructions
  assign wr_val     = {wr_data_hi, wr_data_lo}; // upper half in one register, lower in another
  assign op_val     = {op_mask_hi, op_mask_lo};
  // a read and a write in one cycle: the read is served and the write dropped
  assign rd_req     = ext_ctrl_reg_read_instr;
  assign wr_req     = ext_ctrl_reg_write_instr & ~ext_ctrl_reg_read_instr;
  // privilege and index checks; the index check serves both access paths
  assign ring_ok    = (cpl == RING_0);
  assign index_ok   = (ctrl_index == IDX_ENABLE_MASK); // only index zero exists
  // wide vector issue needs the os enable, both vector bits and a prefix-capable mode
  assign vec_ok     = os_save_en && st_ff.mask[BIT_WIDE_VECTOR] && st_ff.mask[BIT_VECTOR_128]
                      && !xsm_prefix_blocked(real_mode, v86_mode, smm_entry);

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  // pulses default low, levels and data hold their last value
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.rd_valid  = 1'b0;
    nxt_st.wr_done   = 1'b0;
    nxt_st.sv_valid  = 1'b0;
    nxt_st.rs_valid  = 1'b0;
    nxt_st.vec_grant = 1'b0;
    nxt_st.a_valid   = 1'b0;
    nxt_st.gp        = 1'b0;
    nxt_st.ud        = 1'b0;
    nxt_st.supported = xsm_supported();

    // read: any ring, index zero only
    if (rd_req) begin
      if (!os_save_en) begin
        nxt_st.ud = 1'b1;
      end else if (!index_ok) begin
        nxt_st.gp = 1'b1;
      end else begin
        nxt_st.rd_hi    = st_ff.mask[63:32];
        nxt_st.rd_lo    = st_ff.mask[31:0];
        nxt_st.rd_valid = 1'b1; // no ring check on reads
      end
    end else if (wr_req) begin
      // write: checks first, mask untouched on any fault
      if (!os_save_en) begin
        nxt_st.ud = 1'b1;
      end else if (!ring_ok) begin
        nxt_st.gp = 1'b1;
      end else if (!index_ok) begin
        nxt_st.gp = 1'b1;
      end else if (!xsm_legal(wr_val)) begin
        nxt_st.gp = 1'b1;
      end else begin
        nxt_st.mask    = wr_val;
        nxt_st.wr_done = 1'b1;
      end
    end

    // save and restore run in every mode, no mode gate here
    if (extended_save_instr | optimized_save_instr) begin
      nxt_st.sv_mask  = xsm_gate(op_val, st_ff.mask);
      nxt_st.sv_valid = 1'b1;
    end
    if (extended_restore_instr) begin
      nxt_st.rs_mask  = xsm_gate(op_val, st_ff.mask);
      nxt_st.rs_valid = 1'b1;
    end

    // wide vector issue: needs os enable, both vector bits, usable mode
    // refusal only stops issue; no state is cleared on mode changes
    if (vector_instr) begin
      if (!vec_ok) begin
        nxt_st.ud = 1'b1;
      end else begin
        nxt_st.vec_grant = 1'b1;
      end
    end

    // save area query; unknown components answer with size zero
    if (area_req) begin
      nxt_st.a_off   = map_off;
      nxt_st.a_size  = map_hit ? map_size : 16'h0000;
      nxt_st.a_valid = 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  // synchronous reset acts even while the clock enable is low
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_ff           <= '0;
      st_ff.mask      <= MASK_RESET;
      st_ff.supported <= xsm_supported(); // capability never changes after reset
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // -------------------------------------------------------------------
  // outputs, all straight from the state register
  // -------------------------------------------------------------------
  assign rd_data_hi                  = st_ff.rd_hi;
  assign rd_data_lo                  = st_ff.rd_lo;
  assign rd_valid                    = st_ff.rd_valid;
  assign wr_done                     = st_ff.wr_done;
  assign save_component_mask         = st_ff.sv_mask;
  assign save_valid                  = st_ff.sv_valid;
  assign restore_component_mask      = st_ff.rs_mask;
  assign restore_valid               = st_ff.rs_valid;
  assign vector_grant                = st_ff.vec_grant;
  assign area_off                    = st_ff.a_off;
  assign area_size                   = st_ff.a_size;
  assign area_valid                  = st_ff.a_valid;
  assign general_protection_fault    = st_ff.gp;
  assign invalid_opcode_fault        = st_ff.ud;
  assign state_component_enable_mask = st_ff.mask;
  assign supported_component_mask    = st_ff.supported;
  // per component enables decoded from the mask
  assign profiling_extension_enable  = st_ff.mask[BIT_PROFILING];
  assign wide_vector_state_enable    = st_ff.mask[BIT_WIDE_VECTOR];
  assign vector_128_state_enable     = st_ff.mask[BIT_VECTOR_128];
  assign legacy_float_state_enable   = st_ff.mask[BIT_LEGACY_FP];

endmodule
`default_nettype wire

// ===== xsm_ctrl_properties.sv
// checker: timing properties of the extended state enable mask controller
`timescale 1ns/1ps
`default_nettype none
module xsm_ctrl_properties
  import xsm_pkg::*;
#(
  parameter logic PROFILING_SUPPORTED = 1'b0
) (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        clk_en,
  // context and requests
  input wire logic [31:0] cr4,
  input wire logic [1:0]  cpl,
  input wire logic        real_mode,
  input wire logic        v86_mode,
  input wire logic        smm_entry,
  input wire logic        ext_ctrl_reg_read_instr,
  input wire logic        ext_ctrl_reg_write_instr,
  input wire logic [31:0] ctrl_index,
  input wire logic [31:0] wr_data_hi,
  input wire logic [31:0] wr_data_lo,
  input wire logic        extended_save_instr,
  input wire logic        optimized_save_instr,
  input wire logic        extended_restore_instr,
  input wire logic [31:0] op_mask_hi,
  input wire logic [31:0] op_mask_lo,
  input wire logic        vector_instr,
  // answers
  input wire logic [31:0] rd_data_hi,
  input wire logic [31:0] rd_data_lo,
  input wire logic        rd_valid,
  input wire logic        wr_done,
  input wire logic [63:0] save_component_mask,
  input wire logic        save_valid,
  input wire logic [63:0] restore_component_mask,
  input wire logic        restore_valid,
  input wire logic        vector_grant,
  input wire logic        general_protection_fault,
  input wire logic        invalid_opcode_fault,
  input wire logic [63:0] state_component_enable_mask,
  input wire logic [63:0] supported_component_mask
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic [63:0] m;
  logic [63:0] wv;
  logic        okc;
  logic        wbad;
  assign m = state_component_enable_mask;
  assign wv = {wr_data_hi, wr_data_lo};
  assign okc = clk_en && cr4[CR4_OS_SAVE_BIT];
  // bit 62 only passes when the profiling state exists
  assign wbad = wv[63] || (|wv[61:3]) || (wv[62] && !PROFILING_SUPPORTED) || !wv[0] || wv[2:1] == PAIR_ILLEGAL;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_wr;
    okc && ext_ctrl_reg_write_instr && !ext_ctrl_reg_read_instr && cpl == RING_0 && ctrl_index == IDX_ENABLE_MASK;
  endsequence
  property p_init;
    $rose(rstn) |-> m == MASK_RESET && supported_component_mask[2:0] == SUPPORTED_BASE;
  endproperty
  property p_wr_ok;
    s_wr ##0 !wbad |=> wr_done && m == $past(wv);
  endproperty
  property p_wr_bad;
    s_wr ##0 wbad |=> general_protection_fault && !wr_done && $stable(m);
  endproperty
  property p_ring;
    okc && ext_ctrl_reg_write_instr && !ext_ctrl_reg_read_instr && cpl != RING_0 |=> general_protection_fault && $stable(m);
  endproperty
  property p_ud;
    clk_en && !cr4[CR4_OS_SAVE_BIT] && (ext_ctrl_reg_read_instr || ext_ctrl_reg_write_instr)
      |=> invalid_opcode_fault && !rd_valid && !wr_done;
  endproperty
  property p_rd;
    okc && ext_ctrl_reg_read_instr && ctrl_index == IDX_ENABLE_MASK |=> rd_valid && {rd_data_hi, rd_data_lo} == $past(m);
  endproperty
  property p_save;
    clk_en && (extended_save_instr || optimized_save_instr)
      |=> save_valid && save_component_mask == $past({op_mask_hi, op_mask_lo} & m);
  endproperty
  property p_rest;
    clk_en && extended_restore_instr |=> restore_valid && restore_component_mask == $past({op_mask_hi, op_mask_lo} & m);
  endproperty
  property p_vec;
    clk_en && vector_instr
      |=> vector_grant == $past(okc && m[2] && m[1] && !real_mode && !v86_mode && !smm_entry);
  endproperty
  property p_legal;
    m[0] && m[2:1] != PAIR_ILLEGAL && !m[63];
  endproperty

  a_init: assert property (p_init) else $error("mask not one after reset");
  a_wr_ok: assert property (p_wr_ok) else $error("legal write not taken");
  a_wr_bad: assert property (p_wr_bad) else $error("illegal write not refused");
  a_ring: assert property (p_ring) else $error("write outside ring 0 not refused");
  a_ud: assert property (p_ud) else $error("access without enable not refused");
  a_rd: assert property (p_rd) else $error("read data differs from mask");
  a_save: assert property (p_save) else $error("save components wrong");
  a_rest: assert property (p_rest) else $error("restore components wrong");
  a_vec: assert property (p_vec) else $error("vector issue gate wrong");
  a_legal: assert property (p_legal) else $error("mask holds an illegal pattern");
endmodule

bind xsm_ctrl xsm_ctrl_properties #(.PROFILING_SUPPORTED(PROFILING_SUPPORTED)) u_props (.*);
`default_nettype wire

// ===== tb_top.sv
// testbench: directed tests of the extended state enable mask controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import xsm_pkg::*;
  localparam logic [6:0] RD = 7'h40, WR = 7'h20, SV = 7'h10, OS = 7'h08, RS = 7'h04, VI = 7'h02, AR = 7'h01;
  logic core_clk = 1'b0;
  logic rstn, clk_en, real_mode, v86_mode, smm_entry, vector_instr, area_req;
  logic ext_ctrl_reg_read_instr, ext_ctrl_reg_write_instr, rd_valid, wr_done, save_valid, restore_valid;
  logic extended_save_instr, optimized_save_instr, extended_restore_instr, vector_grant, area_valid;
  logic general_protection_fault, invalid_opcode_fault, profiling_extension_enable;
  logic wide_vector_state_enable, vector_128_state_enable, legacy_float_state_enable;
  logic [1:0] cpl;
  logic [5:0] area_comp;
  logic [6:0] st;
  logic [15:0] area_off, area_size;
  logic [31:0] cr4, ctrl_index, wr_data_hi, wr_data_lo, op_mask_hi, op_mask_lo, rd_data_hi, rd_data_lo;
  logic [63:0] save_component_mask, restore_component_mask, state_component_enable_mask, supported_component_mask;
  logic [63:0] bad [6] = '{64'h8000_0000_0000_0007, 64'h4000_0000_0000_0007, 64'h0000_0001_0000_0007,
                           64'h0000_0000_0000_000F, 64'h0000_0000_0000_0006, 64'h0000_0000_0000_0005};
  logic [31:0] area_exp [3] = '{32'h0000_0200, 32'h0200_0040, 32'h0240_0100};
  logic [5:0] area_ids [3] = '{6'h00, 6'h3F, 6'h02};
  int mismatches = 0;
  int n_checks = 0;

  xsm_ctrl u_dut (.*);
  // all request strobes come from one vector so a clear is one assignment
  assign {ext_ctrl_reg_read_instr, ext_ctrl_reg_write_instr, extended_save_instr, optimized_save_instr,
          extended_restore_instr, vector_instr, area_req} = st;
  always #25 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one request; answers are sampled half a cycle after it is taken
  task automatic rq(input logic [6:0] s, input logic [63:0] d);
    @(negedge core_clk);
    st = s;
    {wr_data_hi, wr_data_lo} = d;
    {op_mask_hi, op_mask_lo} = d;
    @(negedge core_clk);
    st = 7'h0;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {st, rstn, clk_en, cpl, real_mode, v86_mode, smm_entry, area_comp, ctrl_index} = '0;
    {cr4, wr_data_hi, wr_data_lo, op_mask_hi, op_mask_lo} = '0;
    cr4[CR4_OS_SAVE_BIT] = 1'b1;
    clk_en = 1'b1;
    repeat (10) @(negedge core_clk);
    rstn = 1'b1;
    chk("mask", 64'h1, state_component_enable_mask);
    chk("supported", 64'h7, supported_component_mask);
    rq(WR, 64'h7);
    chk("wr_done", 64'h1, wr_done);
    chk("enables", 64'h7, {wide_vector_state_enable, vector_128_state_enable, legacy_float_state_enable});
    rq(RD, 64'h0);
    chk("rd_valid", 64'h1, rd_valid);
    chk("rd", 64'h7, {rd_data_hi, rd_data_lo});
    $display("test write and read done");
    foreach (bad[i]) begin
      rq(WR, bad[i]);
      chk("gp", 64'h1, general_protection_fault);
      chk("mask", 64'h7, state_component_enable_mask);
    end
    chk("profiling", 64'h0, profiling_extension_enable);
    cpl = 2'h3;
    rq(WR, 64'h3);
    chk("gp ring", 64'h1, general_protection_fault);
    rq(RD, 64'h0);
    chk("rd ring", 64'h1, rd_valid);
    {cpl, ctrl_index} = 34'h1;
    rq(RD, 64'h0);
    chk("gp index", 64'h1, general_protection_fault);
    {ctrl_index, cr4} = '0;
    rq(RD, 64'h0);
    chk("ud read", 64'h1, invalid_opcode_fault);
    rq(VI, 64'h0);
    chk("ud vector", 64'h1, invalid_opcode_fault);
    cr4[CR4_OS_SAVE_BIT] = 1'b1;
    clk_en = 1'b0;
    rq(WR, 64'h3);
    chk("frozen", 64'h7, state_component_enable_mask);
    clk_en = 1'b1;
    $display("test refusals done");
    real_mode = 1'b1;
    rq(SV | RS, 64'hFFFF_FFFF_FFFF_FFFD);
    chk("save", 64'h5, save_component_mask);
    chk("restore", 64'h5, restore_component_mask);
    chk("sr valid", 64'h3, {save_valid, restore_valid});
    for (int i = 0; i < 3; i++) begin
      {real_mode, v86_mode, smm_entry} = 3'h1 << i;
      rq(VI, 64'h0);
      chk("vector mode", 64'h1, invalid_opcode_fault);
    end
    {real_mode, v86_mode, smm_entry} = 3'h0;
    chk("mask modes", 64'h7, state_component_enable_mask);
    rq(VI, 64'h0);
    chk("grant", 64'h1, vector_grant);
    rq(WR, 64'h3);
    rq(VI, 64'h0);
    chk("no grant", 64'h0, vector_grant);
    rq(OS, 64'hFFFF_FFFF_FFFF_FFFF);
    chk("opt save", 64'h3, save_component_mask);
    $display("test save and vector done");
    foreach (area_ids[i]) begin
      area_comp = area_ids[i];
      rq(AR, 64'h0);
      chk("area", area_exp[i], {area_off, area_size});
      chk("area valid", 64'h1, area_valid);
    end
    rstn = 1'b0;
    @(negedge core_clk);
    rstn = 1'b1;
    chk("mask again", 64'h1, state_component_enable_mask);
    $display("test area and reset done");
    conclude();
  end

  // watchdog against a hung run
  initial begin
    #2000000;
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
